// ==== rtl/brfc_cs_queue.sv ====
// Per coordinate system rotary queue counter and full hysteresis
`timescale 1ns/1ps
module brfc_cs_queue #(
   parameter int CW = 23 // Counter width
) (
   input  wire logic          sys_clk,   // System clock
   input  wire logic          rstn,      // Async reset, low
   input  wire logic          wr_line,   // Line written here
   input  wire logic          exec_line, // Line executed here
   input  wire logic [CW-1:0] on_th,     // Request-on threshold
   input  wire logic [CW-1:0] off_th,    // Request-off threshold
   output logic      [CW-1:0] count_r,   // Queued lines ahead
   output logic               full_r     // Rotary full flag
);

   // -----------------------------------------------------------------
   // Queue depth
   // -----------------------------------------------------------------
   logic [CW-1:0] count_nxt; // Next depth
   logic          can_dec;   // Something left to execute

   assign can_dec = exec_line && (count_r != '0);

   // [R13] depth up on write, down on execute
   always_comb begin
      count_nxt = count_r;
      if (wr_line && !can_dec) begin
         count_nxt = count_r + CW'(1);
      end else if (!wr_line && can_dec) begin
         count_nxt = count_r - CW'(1);
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         count_r <= '0;
      end else begin
         count_r <= count_nxt;
      end
   end

   // -----------------------------------------------------------------
   // Full flag with hysteresis
   // -----------------------------------------------------------------
   // Set only on a write, so a lowered off point alone never sets it
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         full_r <= 1'b0;
      end else if (wr_line && (count_nxt >= off_th)) begin
         // [R4] at or above off point sets
         full_r <= 1'b1;
      end else if (count_nxt < on_th) begin
         // [R1] below on point clears
         full_r <= 1'b0;
      end else if (wr_line && !full_r) begin
         // [R3] below off point stays clear
         full_r <= 1'b0;
      end
      // [R5] otherwise hold
   end

endmodule // brfc_cs_queue

// ==== rtl/brfc_pkg.sv ====
// Package of constants and carrier types for buffer request flow control
package brfc_pkg;

   // -----------------------------------------------------------------
   // Register offsets (byte addresses, one aligned word each)
   // -----------------------------------------------------------------
   localparam logic [7:0] OFF_CTRL     = 8'h00; // Panel input disable
   localparam logic [7:0] OFF_ON_TH    = 8'h04; // Request-on threshold
   localparam logic [7:0] OFF_OFF_TH   = 8'h08; // Request-off threshold
   localparam logic [7:0] OFF_WARN     = 8'h0C; // Fixed warning level
   localparam logic [7:0] OFF_HOST_CS  = 8'h10; // Host-addressed system
   localparam logic [7:0] OFF_STATUS   = 8'h14; // Full flags, request
   localparam logic [7:0] OFF_QCOUNT   = 8'h18; // Queued lines, sel cs
   localparam logic [7:0] OFF_FREE     = 8'h1C; // Free fixed words
   localparam logic [7:0] OFF_IRQ_STAT = 8'h20; // Sticky events
   localparam logic [7:0] OFF_IRQ_MASK = 8'h24; // Event mask

   // -----------------------------------------------------------------
   // Field positions
   // -----------------------------------------------------------------
   localparam int CTRL_PANEL_DIS_BIT = 0;  // Panel inputs disabled
   localparam int STAT_FULL_BIT      = 11; // Full flag position
   localparam int STAT_FIXED_BIT     = 12; // Global fixed full
   localparam int STAT_REQ_BIT       = 0;  // Request line copy
   localparam int IRQ_RISE_BIT       = 0;  // Request rose
   localparam int IRQ_FALL_BIT       = 1;  // Request fell
   localparam int IRQ_W              = 2;  // Event count

   // -----------------------------------------------------------------
   // Reset values
   // -----------------------------------------------------------------
   localparam logic [22:0] RST_ON_TH  = 23'h000005; // Default five
   localparam logic [22:0] RST_OFF_TH = 23'h00000A; // Off point
   localparam logic [22:0] RST_WARN   = 23'h00000A; // Ten long words
   localparam logic        RST_PANEL_DIS = 1'b1;    // Panel disabled
   localparam logic [22:0] RST_FREE   = 23'h000400; // Free words

   // -----------------------------------------------------------------
   // Timing: request low pulse after each write
   // -----------------------------------------------------------------
   localparam int CLK_NS     = 10;  // Clock period
   localparam int DIP_NS     = 20;  // Least low time after write
   localparam int DIP_CYC    = (DIP_NS + CLK_NS - 1) / CLK_NS;

   // -----------------------------------------------------------------
   // Carrier types
   // -----------------------------------------------------------------
   typedef struct packed {
      logic [7:0]  addr;  // Byte address
      logic [31:0] wdata; // Write data
      logic        wr;    // Write strobe
      logic        rd;    // Read strobe
   } brfc_bus_t;

   typedef struct packed {
      logic       line_wr;   // Host wrote a line
      logic       fixed;     // Line went to fixed buffer
      logic [1:0] cs;        // Target coordinate system
   } brfc_line_t;

endpackage

// ==== rtl/brfc_top.sv ====
// Buffer request flow control: top with register file and request line
// How it works
// [R1] Below on point: request high, full clear
// [R2] Rotary write dips request low briefly
// [R3] Below off point after write: request high
// [R4] At off point after write: hold low, full
// [R5] Full holds until below on point
// [R6] Request follows panel or host system
// [R7] Full flags readable, request is inverse
// [R8] Request edges interrupt; status also pollable
// [R9] Fixed write dips request low briefly
// [R10] Free above warning: request high, clear
// [R11] Free at/below warning: low, fixed full
// [R12] Host normally pauses while request low
// [R13] Count queued lines per coordinate system
//
// The register addresses and strobed register access were chosen for this implementation.
`timescale 1ns/1ps
module brfc_top #(
   parameter int NCS = 4,  // Coordinate systems
   parameter int CW  = 23  // Threshold and count width
) (
   input  wire logic                 sys_clk,       // System clock
   input  wire logic                 rstn,          // Async reset, low
   input  wire brfc_pkg::brfc_bus_t  bus,           // Register port
   output logic      [31:0]          rdata_r,       // Read data
   input  wire brfc_pkg::brfc_line_t line,          // Host line writes
   input  wire logic [NCS-1:0]       exec_line,     // Line executed
   input  wire logic [1:0]           panel_cs_select_pins, // Pin select
   input  wire logic                 fixed_consume, // Word used
   input  wire logic                 fixed_release, // Word freed
   output logic                      buffer_request_line_r, // Request
   output logic                      irq_r          // Interrupt level
);

   // -----------------------------------------------------------------
   // Register state
   // -----------------------------------------------------------------
   logic          panel_input_disable_r;       // 1: host system drives
   logic [CW-1:0] request_on_threshold_r;      // On point
   logic [CW-1:0] request_off_threshold_r;     // Off point
   logic [CW-1:0] fixed_buffer_warning_level_r;// Warning words
   logic [1:0]    host_cs_r;                   // Host-addressed system
   logic [CW-1:0] free_r;                      // Free fixed words
   logic          fixed_full_r;                // Global fixed full
   // Declared ahead of the event registers that take their width from it
   localparam int IRQ_W_L = brfc_pkg::IRQ_W;   // Local event count
   logic [IRQ_W_L-1:0] irq_stat_r;             // Sticky events
   logic [IRQ_W_L-1:0] irq_mask_r;             // Event mask

   // -----------------------------------------------------------------
   // Pin synchroniser, three stages, accept when last two agree
   // -----------------------------------------------------------------
   logic [1:0] pan_s1_r;  // First stage, read only by second
   logic [1:0] pan_s2_r;  // Second stage
   logic [1:0] pan_s3_r;  // Third stage
   logic [1:0] pan_cs_r;  // Accepted panel selection

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         pan_s1_r <= 2'h0;
         pan_s2_r <= 2'h0;
         pan_s3_r <= 2'h0;
         pan_cs_r <= 2'h0;
      end else begin
         pan_s1_r <= panel_cs_select_pins;
         pan_s2_r <= pan_s1_r;
         pan_s3_r <= pan_s2_r;
         if (pan_s2_r == pan_s3_r) begin
            pan_cs_r <= pan_s3_r;
         end
      end
   end

   // -----------------------------------------------------------------
   // Per coordinate system queues
   // -----------------------------------------------------------------
   logic [NCS-1:0]         rot_wr;   // Rotary write per system
   logic [NCS-1:0]         full_v;   // Full flags
   logic [NCS-1:0][CW-1:0] count_v;  // Queue depths

   genvar gi;
   generate
      for (gi = 0; gi < NCS; gi++) begin : g_cs
         assign rot_wr[gi] = line.line_wr && !line.fixed &&
                             (line.cs == 2'(gi));
         brfc_cs_queue #(.CW(CW)) u_q (
            .sys_clk   (sys_clk),
            .rstn      (rstn),
            .wr_line   (rot_wr[gi]),
            .exec_line (exec_line[gi]),
            .on_th     (request_on_threshold_r),
            .off_th    (request_off_threshold_r),
            .count_r   (count_v[gi]),
            .full_r    (full_v[gi])
         );
      end
   endgenerate

   // -----------------------------------------------------------------
   // Selected system
   // -----------------------------------------------------------------
   logic [1:0] sel_cs; // System the request reflects

   // [R6] panel pins or host-addressed system
   assign sel_cs = panel_input_disable_r ? host_cs_r : pan_cs_r;

   // -----------------------------------------------------------------
   // Fixed buffer free words and full flag
   // -----------------------------------------------------------------
   logic fix_wr;          // Line into open fixed buffer
   logic [CW-1:0] free_nxt; // Free words after this cycle

   assign fix_wr = line.line_wr && line.fixed;

   always_comb begin
      free_nxt = free_r;
      if (fixed_consume && !fixed_release && free_r != '0) begin
         free_nxt = free_r - CW'(1);
      end else if (fixed_release && !fixed_consume &&
                   free_r != {CW{1'b1}}) begin
         free_nxt = free_r + CW'(1);
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         free_r <= CW'(brfc_pkg::RST_FREE);
      end else begin
         free_r <= free_nxt;
      end
   end

   // Judged only on a fixed write; it holds between writes
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         fixed_full_r <= 1'b0;
      end else if (fix_wr) begin
         // [R10] [R11] compare free words with warning
         fixed_full_r <= (free_nxt <= fixed_buffer_warning_level_r);
      end
   end

   // -----------------------------------------------------------------
   // Request line with a dip after every write
   // -----------------------------------------------------------------
   localparam int DW = 4; // Dip counter width
   logic [DW-1:0] dip_r;   // Remaining dip cycles
   logic          any_wr;  // Any line write
   logic          req_nxt; // Next request level

   assign any_wr = line.line_wr;

   // [R2] [R9] force low for the dip after any write
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         dip_r <= '0;
      end else if (any_wr) begin
         dip_r <= DW'(brfc_pkg::DIP_CYC);
      end else if (dip_r != '0) begin
         dip_r <= dip_r - DW'(1);
      end
   end

   // [R7] request is inverse of the reflected full state
   always_comb begin
      req_nxt = !full_v[sel_cs] && !fixed_full_r;
      if (any_wr || dip_r > DW'(1)) begin
         req_nxt = 1'b0;
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         buffer_request_line_r <= 1'b0;
      end else begin
         buffer_request_line_r <= req_nxt;
      end
   end

   // -----------------------------------------------------------------
   // Interrupt events from request edges
   // -----------------------------------------------------------------
   logic [IRQ_W_L-1:0] ev;     // Events this cycle
   logic [IRQ_W_L-1:0] clr_w;  // Write-one-to-clear bits
   logic               wr_hit; // Write to event status

   // [R8] rising and falling request edges
   assign ev[brfc_pkg::IRQ_RISE_BIT] = req_nxt && !buffer_request_line_r;
   assign ev[brfc_pkg::IRQ_FALL_BIT] = !req_nxt && buffer_request_line_r;
   assign wr_hit = bus.wr && (bus.addr == brfc_pkg::OFF_IRQ_STAT);
   assign clr_w  = wr_hit ? bus.wdata[IRQ_W_L-1:0] : '0;

   // Set wins over clear in the same cycle
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         irq_stat_r <= '0;
      end else begin
         irq_stat_r <= (irq_stat_r & ~clr_w) | ev;
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= |(((irq_stat_r & ~clr_w) | ev) & irq_mask_r);
      end
   end

   // -----------------------------------------------------------------
   // Register writes
   // -----------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         panel_input_disable_r        <= brfc_pkg::RST_PANEL_DIS;
         request_on_threshold_r       <= CW'(brfc_pkg::RST_ON_TH);
         request_off_threshold_r      <= CW'(brfc_pkg::RST_OFF_TH);
         fixed_buffer_warning_level_r <= CW'(brfc_pkg::RST_WARN);
         host_cs_r                    <= 2'h0;
         irq_mask_r                   <= '0;
      end else if (bus.wr) begin
         case (bus.addr)
            brfc_pkg::OFF_CTRL: begin
               panel_input_disable_r <=
                  bus.wdata[brfc_pkg::CTRL_PANEL_DIS_BIT];
            end
            brfc_pkg::OFF_ON_TH: begin
               request_on_threshold_r  <= bus.wdata[CW-1:0];
            end
            brfc_pkg::OFF_OFF_TH: begin
               request_off_threshold_r <= bus.wdata[CW-1:0];
            end
            brfc_pkg::OFF_WARN: begin
               fixed_buffer_warning_level_r <= bus.wdata[CW-1:0];
            end
            brfc_pkg::OFF_HOST_CS:  host_cs_r  <= bus.wdata[1:0];
            brfc_pkg::OFF_IRQ_MASK: irq_mask_r <= bus.wdata[IRQ_W_L-1:0];
            default: begin
               // Read-only or unmapped: ignored
            end
         endcase
      end
   end

   // -----------------------------------------------------------------
   // Register reads, data one cycle after the strobe only
   // -----------------------------------------------------------------
   logic [31:0] rd_nxt; // Read mux

   always_comb begin
      rd_nxt = 32'h0;
      case (bus.addr)
         brfc_pkg::OFF_CTRL:     rd_nxt[0] = panel_input_disable_r;
         brfc_pkg::OFF_ON_TH:    rd_nxt[CW-1:0] = request_on_threshold_r;
         brfc_pkg::OFF_OFF_TH:   rd_nxt[CW-1:0] = request_off_threshold_r;
         brfc_pkg::OFF_WARN:     rd_nxt[CW-1:0] = fixed_buffer_warning_level_r;
         brfc_pkg::OFF_HOST_CS:  rd_nxt[1:0] = host_cs_r;
         brfc_pkg::OFF_STATUS: begin
            // [R7] selected full, fixed full, request
            rd_nxt[brfc_pkg::STAT_FULL_BIT]  = full_v[sel_cs];
            rd_nxt[brfc_pkg::STAT_FIXED_BIT] = fixed_full_r;
            rd_nxt[brfc_pkg::STAT_REQ_BIT]   = buffer_request_line_r;
            rd_nxt[16+NCS-1:16]              = full_v;
         end
         brfc_pkg::OFF_QCOUNT:   rd_nxt[CW-1:0] = count_v[sel_cs];
         brfc_pkg::OFF_FREE:     rd_nxt[CW-1:0] = free_r;
         brfc_pkg::OFF_IRQ_STAT: rd_nxt[IRQ_W_L-1:0] = irq_stat_r;
         brfc_pkg::OFF_IRQ_MASK: rd_nxt[IRQ_W_L-1:0] = irq_mask_r;
         default:                rd_nxt = 32'h0;
      endcase
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         rdata_r <= 32'h0;
      end else begin
         rdata_r <= bus.rd ? rd_nxt : 32'h0;
      end
   end

   // -----------------------------------------------------------------
   // Assertions
   // -----------------------------------------------------------------
   property p_dip;
      @(posedge sys_clk) disable iff (!rstn)
      line.line_wr |=> !buffer_request_line_r;
   endproperty
   a_dip: assert property (p_dip) // [R2]
      else $error("request not low after write");

   property p_full_low;
      @(posedge sys_clk) disable iff (!rstn)
      full_v[sel_cs] && $stable(sel_cs) |=> !buffer_request_line_r;
   endproperty
   a_full_low: assert property (p_full_low) // [R4]
      else $error("request high while full");

   property p_fix_low;
      @(posedge sys_clk) disable iff (!rstn)
      fixed_full_r |=> !buffer_request_line_r;
   endproperty
   a_fix_low: assert property (p_fix_low) // [R11]
      else $error("request high while fixed full");

   property p_fix_set;
      @(posedge sys_clk) disable iff (!rstn)
      fix_wr && (free_nxt <= fixed_buffer_warning_level_r) |=> fixed_full_r;
   endproperty
   a_fix_set: assert property (p_fix_set) // [R11]
      else $error("fixed full not set");

   property p_fix_clr;
      @(posedge sys_clk) disable iff (!rstn)
      fix_wr && (free_nxt > fixed_buffer_warning_level_r) |=> !fixed_full_r;
   endproperty
   a_fix_clr: assert property (p_fix_clr) // [R10]
      else $error("fixed full set above warning");

   property p_rise;
      @(posedge sys_clk) disable iff (!rstn)
      !line.line_wr && dip_r == '0 && !full_v[sel_cs] && !fixed_full_r
      |=> buffer_request_line_r;
   endproperty
   a_rise: assert property (p_rise) // [R1]
      else $error("request not high when room");

   property p_sel;
      @(posedge sys_clk) disable iff (!rstn)
      panel_input_disable_r |-> sel_cs == host_cs_r;
   endproperty
   a_sel: assert property (p_sel) // [R6]
      else $error("wrong system reflected");

   property p_irq;
      @(posedge sys_clk) disable iff (!rstn)
      $rose(buffer_request_line_r) && irq_mask_r[0] |-> irq_r;
   endproperty
   a_irq: assert property (p_irq) // [R8]
      else $error("no interrupt on request rise");

   c_full: cover property (@(posedge sys_clk) disable iff (!rstn)
      $rose(full_v[0]));
   c_unfull: cover property (@(posedge sys_clk) disable iff (!rstn)
      $fell(full_v[0]));
   c_fixfull: cover property (@(posedge sys_clk) disable iff (!rstn)
      $rose(fixed_full_r));

endmodule // brfc_top

// ==== test/brfc_host_model.sv ====
// Host model that writes program lines toward the device
`timescale 1ns/1ps
module brfc_host_model (
   input  wire logic            sys_clk, // System clock
   input  wire logic            req,     // Request line seen
   output brfc_pkg::brfc_line_t line     // Line writes out
);
   // ----------------------------------------
   // Line traffic
   // ----------------------------------------
   initial line = '0;

   // One line is a one cycle pulse
   task automatic send_line(input logic fx, input logic [1:0] cs);
      @(posedge sys_clk);
      line <= '{line_wr: 1'b1, fixed: fx, cs: cs};
      @(posedge sys_clk);
      line <= '0;
   endtask

   // pause while request low
   // Bounded, so a stuck request cannot hang the host
   task automatic wait_ready(output logic ok);
      ok = 1'b0;
      for (int n = 0; n < 64 && !ok; n++) begin
         @(posedge sys_clk);
         ok = (req === 1'b1);
      end
   endtask
endmodule // brfc_host_model

// ==== test/brfc_tb_top.sv ====
// Self-checking bench for buffer request flow control
`timescale 1ns/1ps
module brfc_tb_top;
   // ----------------------------------------
   // Signals
   // ----------------------------------------
   logic                 sys_clk = 1'b0; // 100 MHz clock
   logic                 rstn    = 1'b0; // Reset, low
   brfc_pkg::brfc_bus_t  bus     = '0;   // Register port
   logic [31:0]          rdata_r;        // Read data
   brfc_pkg::brfc_line_t line;           // Host line writes
   logic [3:0]           exec_line = '0; // Executed lines
   logic [1:0]           pins    = '0;   // Panel select pins
   logic                 fx_use  = 1'b0; // Fixed word used
   logic                 fx_rel  = 1'b0; // Fixed word freed
   logic                 req;            // Request line
   logic                 irq;            // Interrupt level
   logic [31:0]          rv;             // Last read value
   logic                 ok, ia;         // Scratch flags
   int                   bad_count = 0;  // Mismatches
   int                   cmp_count = 0;  // Comparisons
   logic [7:0]  ra [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h1C, 8'h24};
   logic [31:0] rx [7] = '{32'h1, 32'h5, 32'hA, 32'hA, 32'h0, 32'h400, 32'h0};

   always #5 sys_clk = ~sys_clk;

   brfc_top #(.NCS(4), .CW(23)) u_brfc_top (
      .sys_clk(sys_clk), .rstn(rstn), .bus(bus), .rdata_r(rdata_r),
      .line(line), .exec_line(exec_line), .panel_cs_select_pins(pins),
      .fixed_consume(fx_use), .fixed_release(fx_rel),
      .buffer_request_line_r(req), .irq_r(irq));

   brfc_host_model u_brfc_host_model (
      .sys_clk(sys_clk), .req(req), .line(line));

   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic check(input string what, input logic [31:0] seen, exp);
      cmp_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
      end
   endtask

   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge sys_clk);
      bus.wr <= 1'b0;
   endtask

   // Data stand only in the cycle after the strobe
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      @(posedge sys_clk);
      bus <= '{addr: a, wdata: '0, wr: 1'b0, rd: 1'b1};
      @(posedge sys_clk);
      bus.rd <= 1'b0;
      #1 check("rdata", rdata_r, e);
   endtask

   // Line write, request dip, then settled level
   task automatic line_chk(input logic fx, cs1, input logic e);
      u_brfc_host_model.send_line(fx, {1'b0, cs1});
      #1 check("req dip", req, 1'b0);
      @(posedge sys_clk);
      #1 check("req dip", req, 1'b0);
      @(posedge sys_clk);
      #1 check("req after", req, e);
   endtask

   task automatic exec_one(input int cs);
      @(posedge sys_clk);
      exec_line[cs] <= 1'b1;
      @(posedge sys_clk);
      exec_line <= '0;
      repeat (3) @(posedge sys_clk);
   endtask

   task automatic results;
      $display("Counts: %0d compared, %0d failed", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial begin
      @(posedge sys_clk);
      #1 check("req in reset", req, 1'b0);
      repeat (2) @(posedge sys_clk);
      rstn <= 1'b1;
      for (int i = 0; i < 7; i++) rd_chk(ra[i], rx[i]);
      rd_chk(8'h3C, 32'h0);
      wr_reg(8'h14, 32'hFFFFFFFF);
      rd_chk(8'h14, 32'h1);
      $display("test defaults done");
      // Fill one rotary queue to the off point and one line past it
      for (int i = 0; i < 9; i++) line_chk(1'b0, 1'b0, 1'b1);
      line_chk(1'b0, 1'b0, 1'b0);
      rd_chk(8'h14, 32'h00010800);
      line_chk(1'b0, 1'b0, 1'b0);
      rd_chk(8'h18, 32'hB);
      // Drain: full holds until below on point
      for (int i = 0; i < 6; i++) begin
         exec_one(0);
         #1 check("req held", req, 1'b0);
      end
      exec_one(0);
      #1 check("req on", req, 1'b1);
      rd_chk(8'h14, 32'h1);
      rd_chk(8'h18, 32'h4);
      u_brfc_host_model.wait_ready(ok);
      check("ready", ok, 1'b1);
      $display("test rotary done");
      // Request edges raise events; mask sense compared
      wr_reg(8'h20, 32'h3);
      rd_chk(8'h20, 32'h0);
      line_chk(1'b0, 1'b0, 1'b1);
      rd_chk(8'h20, 32'h3);
      wr_reg(8'h24, 32'h0);
      @(posedge sys_clk);
      #1 ia = irq;
      wr_reg(8'h24, 32'h3);
      @(posedge sys_clk);
      #1 check("irq mask", ia ^ irq, 1'b1);
      wr_reg(8'h20, 32'h3);
      wr_reg(8'h24, 32'h0);
      @(posedge sys_clk);
      #1 check("irq clear", irq, 1'b0);
      wr_reg(8'h24, 32'h3);
      @(posedge sys_clk);
      #1 check("irq clear", irq, 1'b0);
      $display("test interrupt done");
      // Selection: host system, then panel pins
      for (int i = 0; i < 10; i++) line_chk(1'b0, 1'b1, 1'b1);
      rd_chk(8'h14, 32'h00020001);
      wr_reg(8'h10, 32'h1);
      rd_chk(8'h14, 32'h00020800);
      wr_reg(8'h00, 32'h0);
      repeat (6) @(posedge sys_clk);
      #1 check("panel cs0", req, 1'b1);
      pins <= 2'h1;
      repeat (6) @(posedge sys_clk);
      #1 check("panel cs1", req, 1'b0);
      wr_reg(8'h00, 32'h1);
      wr_reg(8'h10, 32'h0);
      $display("test select done");
      // Fixed buffer near the warning level
      @(posedge sys_clk);
      fx_use <= 1'b1;
      repeat (1013) @(posedge sys_clk);
      fx_use <= 1'b0;
      rd_chk(8'h1C, 32'hB);
      line_chk(1'b1, 1'b0, 1'b1);
      rd_chk(8'h14, 32'h00020001);
      @(posedge sys_clk);
      fx_use <= 1'b1;
      @(posedge sys_clk);
      fx_use <= 1'b0;
      line_chk(1'b1, 1'b0, 1'b0);
      rd_chk(8'h14, 32'h00021000);
      @(posedge sys_clk);
      fx_rel <= 1'b1;
      @(posedge sys_clk);
      fx_rel <= 1'b0;
      line_chk(1'b1, 1'b0, 1'b1);
      rd_chk(8'h14, 32'h00020001);
      $display("test fixed done");
      results();
   end

   // Watchdog: tests need about 12 us
   initial begin
      #200us;
      bad_count++;
      results();
   end
endmodule // brfc_tb_top
